//--- shared/unbe_pkg.sv
// Shared constants, register map and types of the serial port
package unbe_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned DIV_W  = 13;
   localparam int unsigned SEL_W  = 4;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_BAUD_HI    = 8'h40;
   localparam logic [7:0] IDX_BAUD_LO    = 8'h41;
   localparam logic [7:0] IDX_CTRL_ONE   = 8'h42;
   localparam logic [7:0] IDX_CTRL_TWO   = 8'h43;
   localparam logic [7:0] IDX_STATUS     = 8'h44;
   localparam logic [7:0] IDX_CTRL_THREE = 8'h46;
   localparam logic [7:0] IDX_DATA       = 8'h47;

   // Reset values
   localparam logic [DIV_W-1:0] BAUD_RESET     = 13'h0001;
   localparam logic [7:0]       CTRL_ONE_RESET = 8'h00;
   localparam logic [7:0]       CTRL_TWO_RESET = 8'h00;
   localparam logic [7:0]       DATA_RESET     = 8'h00;
   localparam logic [7:0]       STATUS_RESET   = 8'hc0;
   localparam logic [7:0]       CTRL3_RESET    = 8'h00;

   // Field positions in control one and two; width of baud high
   localparam int unsigned C1_LOOP = 7;
   localparam int unsigned C1_RECEIVER_SOURCE_SELECT = 5;
   localparam int unsigned C1_M    = 4;
   localparam int unsigned C1_PE   = 1;
   localparam int unsigned C1_PT   = 0;
   localparam int unsigned C2_TE   = 3;
   localparam int unsigned C2_RE   = 2;
   localparam int unsigned BAUD_HI_W = 5;

   // Sixteen sub-bit samples per bit, counted RT1 as 0
   localparam logic [3:0] RT3      = 4'h2;
   localparam logic [3:0] RT5      = 4'h4;
   localparam logic [3:0] RT7      = 4'h6;
   localparam logic [3:0] RT8      = 4'h7;
   localparam logic [3:0] RT9      = 4'h8;
   localparam logic [3:0] RT10     = 4'h9;
   localparam logic [3:0] RT16     = 4'hf;
   localparam logic [3:0] RT_RESYNC = 4'ha;
   localparam logic [3:0] RT2      = 4'h1;

   // Transmit frame lengths with start and stop; receive data bit counts; parity masks
   localparam logic [3:0] TX_LEN8 = 4'ha;
   localparam logic [3:0] TX_LEN9 = 4'hb;
   localparam logic [3:0] RX_BITS8 = 4'h8;
   localparam logic [3:0] RX_BITS9 = 4'h9;
   localparam logic [8:0] MASK_PAR8 = 9'h07f;
   localparam logic [8:0] MASK_PAR9 = 9'h0ff;

   typedef struct packed {
      logic rx9;
      logic tx9;
      logic pin_dir;
      logic inv;
      logic overrun_irq_enable;
      logic noise_irq_enable;
      logic framing_irq_enable;
      logic parity_irq_enable;
   } unbe_ctrl3_t;

   typedef struct packed {
      logic tdre;
      logic tc;
      logic rdrf;
      logic idle;
      logic ovr;
      logic noise;
      logic frame;
      logic parity;
   } unbe_status_t;

   typedef struct packed {
      logic [8:0] word;
      logic       noise;
      logic       frame;
      logic       parity;
   } unbe_rx_frame_t;

   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} unbe_tx_state_t;
   typedef enum logic [1:0] {
      RX_HUNT  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11,
      RX_STOP  = 2'b10
   } unbe_rx_state_t;

   function automatic logic idx_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] idx);
      return adr == {2'b00, idx, 2'b00};
   endfunction

   function automatic logic parity_of(input logic [8:0] bits, input logic [8:0] mask,
                                      input logic odd);
      return (^(bits & mask)) ^ odd;
   endfunction

   function automatic logic majority(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction
endpackage

//--- verilog/unbe_baud_gen.sv
// Baud generator giving one tick per sixteenth of a bit
`timescale 1ns/10ps
module unbe_baud_gen #(
   parameter int unsigned DIV_W = 13
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  tick
);
   logic [DIV_W-1:0] count;

   always_ff @(posedge mclk) begin
      if (!rst_n || divisor == '0) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (count >= divisor - 1'b1) begin
         count <= '0;
         tick  <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule // unbe_baud_gen

//--- verilog/unbe_serial_port.sv
// Serial port with ninth bit, error interrupt and classic Wishbone registers
// How it works
// - Control three bit 7 reads ninth received bit
// - Bit 6 gives ninth transmitted bit in nine-bit mode when parity is off
// - Bit 5 sets single-wire pin direction
// - Bit 4 inverts whole transmit line
// - Bit 3 gates overrun onto interrupt
// - Bit 2 gates noise onto interrupt
// - Bit 1 gates framing error onto interrupt
// - Bit 0 gates parity error onto interrupt
// - Data address: read receive, write transmit buffer
// - Data accesses finish status flag clearing
// - Independent transmitter, receiver, one baud generator
// - Baud generator runs on die-to-die clock
// - Receiver realigns on data-bit falling edges at RT_RESYNC or later
// - Both ends keep baud rates closely matched
// - Frame: low start, data LSB first, high stop
// - Transmit shifter ten or eleven bits
// - Receiver samples sixteen times per bit
`timescale 1ns/10ps
module unbe_serial_port (
   input  wire logic                         mclk,
   input  wire logic                         rst_n,
   input  wire logic                         wb_cyc,
   input  wire logic                         wb_stb,
   input  wire logic                         wb_we,
   input  wire logic [unbe_pkg::ADDR_W-1:0]  wb_adr,
   input  wire logic [unbe_pkg::SEL_W-1:0]   wb_sel,
   input  wire logic [unbe_pkg::DATA_W-1:0]  wb_dat_w,
   output logic      [unbe_pkg::DATA_W-1:0]  wb_dat_r,
   output logic                              wb_ack,
   input  wire logic                         rx_pin,
   input  wire logic                         tx_pin_in,
   output logic                              tx_pin,
   output logic                              tx_pin_oe_n,
   output logic                              error_irq
);
   logic [unbe_pkg::DIV_W-1:0] baud_div;
   logic [7:0]                 ctrl_one;
   logic [7:0]                 ctrl_two;
   unbe_pkg::unbe_ctrl3_t      ctrl3;
   unbe_pkg::unbe_status_t     status;
   logic [7:0]                 rx_buf;
   logic [7:0]                 tx_buf;
   logic                       tick;
   logic                       req;
   logic                       wr;
   logic                       rd;
   logic                       rx_arm;
   logic                       tx_arm;
   logic                       data_rd_clear;
   logic                       data_wr_clear;
   logic                       nine;
   logic                       single_wire;

   assign req  = wb_cyc & wb_stb & ~wb_ack;
   assign wr   = req & wb_we & wb_sel[0];
   assign rd   = req & ~wb_we;
   assign nine = ctrl_one[unbe_pkg::C1_M];
   assign single_wire = ctrl_one[unbe_pkg::C1_LOOP] & ctrl_one[unbe_pkg::C1_RECEIVER_SOURCE_SELECT];

   // Shared baud generator on the die-to-die clock
   unbe_baud_gen #(
      .DIV_W   (unbe_pkg::DIV_W)
   ) u_baud (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .divisor (baud_div),
      .tick    (tick)
   );

   // Bus acknowledge and read data
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wb_ack   <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
      end else begin
         wb_ack <= req;
         if (rd) begin
            wb_dat_r <= 32'h0000_0000;
            if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_BAUD_HI)) begin
               wb_dat_r[unbe_pkg::BAUD_HI_W-1:0] <=
                  baud_div[unbe_pkg::DIV_W-1:unbe_pkg::DIV_W-unbe_pkg::BAUD_HI_W];
            end else if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_BAUD_LO)) begin
               wb_dat_r[7:0] <= baud_div[7:0];
            end else if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_CTRL_ONE)) begin
               wb_dat_r[7:0] <= ctrl_one;
            end else if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_CTRL_TWO)) begin
               wb_dat_r[7:0] <= ctrl_two;
            end else if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_STATUS)) begin
               wb_dat_r[7:0] <= status;
            end else if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_CTRL_THREE)) begin
               wb_dat_r[7:0] <= ctrl3;
            end else if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_DATA)) begin
               wb_dat_r[7:0] <= rx_buf;
            end
         end
      end
   end

   // Writable configuration registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         baud_div <= unbe_pkg::BAUD_RESET;
         ctrl_one <= unbe_pkg::CTRL_ONE_RESET;
         ctrl_two <= unbe_pkg::CTRL_TWO_RESET;
      end else if (wr) begin
         if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_BAUD_HI)) begin
            baud_div[unbe_pkg::DIV_W-1:unbe_pkg::DIV_W-unbe_pkg::BAUD_HI_W] <=
               wb_dat_w[unbe_pkg::BAUD_HI_W-1:0];
         end
         if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_BAUD_LO)) begin
            baud_div[7:0] <= wb_dat_w[7:0];
         end
         if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_CTRL_ONE)) begin
            ctrl_one <= wb_dat_w[7:0];
         end
         if (unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_CTRL_TWO)) begin
            ctrl_two <= wb_dat_w[7:0];
         end
      end
   end

   // Transmit buffer, loaded on every data write that selects byte lane 0
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_buf <= unbe_pkg::DATA_RESET;
      end else if (wr && unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_DATA)) begin
         tx_buf <= wb_dat_w[7:0];
      end
   end

   // Clearing sequence: status read arms, data access completes
   assign data_rd_clear = rd & rx_arm & unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_DATA);
   assign data_wr_clear = wr & tx_arm & unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_DATA);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_arm <= 1'b0;
         tx_arm <= 1'b0;
      end else if (rd && unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_STATUS)) begin
         rx_arm <= status.rdrf | status.ovr | status.noise | status.frame | status.parity;
         tx_arm <= status.tdre | status.tc;
      end else begin
         if (data_rd_clear) begin
            rx_arm <= 1'b0;
         end
         if (data_wr_clear) begin
            tx_arm <= 1'b0;
         end
      end
   end

   // Transmitter
   unbe_pkg::unbe_tx_state_t tx_state;
   logic [10:0]              tx_shift;
   logic [3:0]               tx_left;
   logic [3:0]               tx_rt;
   logic                     bit_tick;
   logic                     tx_take;
   logic                     tx_done;
   logic                     tx_line;
   logic                     tx_ready;
   logic [8:0]               tx_word;
   logic [10:0]              tx_frame;

   assign bit_tick = tick & (tx_rt == unbe_pkg::RT16);
   assign tx_ready = ctrl_two[unbe_pkg::C2_TE] & ~status.tdre;
   assign tx_line  = (tx_state == unbe_pkg::TX_SHIFT) ? tx_shift[0] : 1'b1;

   always_comb begin
      tx_word = nine ? {ctrl3.tx9, tx_buf} : {1'b1, tx_buf};
      if (ctrl_one[unbe_pkg::C1_PE]) begin
         if (nine) begin
            tx_word[8] = unbe_pkg::parity_of(tx_word, unbe_pkg::MASK_PAR9,
                                             ctrl_one[unbe_pkg::C1_PT]);
         end else begin
            tx_word[7] = unbe_pkg::parity_of(tx_word, unbe_pkg::MASK_PAR8,
                                             ctrl_one[unbe_pkg::C1_PT]);
         end
      end
      tx_frame = {1'b1, tx_word, 1'b0};
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_rt <= 4'h0;
      end else if (tick) begin
         tx_rt <= tx_rt + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_state <= unbe_pkg::TX_IDLE;
         tx_shift <= '1;
         tx_left  <= 4'h0;
         tx_take  <= 1'b0;
         tx_done  <= 1'b0;
      end else begin
         tx_take <= 1'b0;
         tx_done <= 1'b0;
         if (bit_tick) begin
            unique case (tx_state)
               unbe_pkg::TX_IDLE: begin
                  if (tx_ready) begin
                     tx_shift <= tx_frame;
                     tx_left  <= nine ? unbe_pkg::TX_LEN9 : unbe_pkg::TX_LEN8;
                     tx_take  <= 1'b1;
                     tx_state <= unbe_pkg::TX_SHIFT;
                  end
               end
               unbe_pkg::TX_SHIFT: begin
                  if (tx_left == 4'h1) begin
                     if (tx_ready) begin
                        tx_shift <= tx_frame;
                        tx_left  <= nine ? unbe_pkg::TX_LEN9 : unbe_pkg::TX_LEN8;
                        tx_take  <= 1'b1;
                     end else begin
                        tx_state <= unbe_pkg::TX_IDLE;
                        tx_done  <= 1'b1;
                     end
                  end else begin
                     tx_shift <= {1'b1, tx_shift[10:1]};
                     tx_left  <= tx_left - 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Pin drive and direction
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_pin      <= 1'b1;
         tx_pin_oe_n <= 1'b1;
      end else begin
         tx_pin <= tx_line ^ ctrl3.inv;
         if (single_wire) begin
            tx_pin_oe_n <= ~ctrl3.pin_dir;
         end else begin
            tx_pin_oe_n <= ~(ctrl_two[unbe_pkg::C2_TE] | (tx_state == unbe_pkg::TX_SHIFT));
         end
      end
   end

   // Input synchronisers
   logic rx_s1;
   logic rx_s2;
   logic txp_s1;
   logic txp_s2;
   logic rx_line;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_s1  <= 1'b1;
         rx_s2  <= 1'b1;
         txp_s1 <= 1'b1;
         txp_s2 <= 1'b1;
      end else begin
         rx_s1  <= rx_pin;
         rx_s2  <= rx_s1;
         txp_s1 <= tx_pin_in;
         txp_s2 <= txp_s1;
      end
   end

   always_comb begin
      if (single_wire) begin
         rx_line = txp_s2;
      end else if (ctrl_one[unbe_pkg::C1_LOOP]) begin
         rx_line = tx_line;
      end else begin
         rx_line = rx_s2;
      end
   end

   // Receiver
   unbe_pkg::unbe_rx_state_t rx_state;
   unbe_pkg::unbe_rx_frame_t rx_frame;
   logic [2:0]               hist;
   logic [2:0]               votes;
   logic [3:0]               rx_rt;
   logic [3:0]               rx_bit;
   logic [8:0]               rx_shift;
   logic                     rx_noise;
   logic                     rx_done;
   logic                     falling;
   logic                     bit_val;
   logic                     bit_noisy;
   logic                     resync;
   logic                     rx_par_bad;

   assign falling   = (hist == 3'b111) & ~rx_line;
   assign bit_val   = unbe_pkg::majority({votes[1:0], rx_line});
   assign bit_noisy = ~(&{votes[1:0], rx_line}) & (|{votes[1:0], rx_line});
   assign resync    = (rx_state == unbe_pkg::RX_DATA) & falling &
                      (rx_rt >= unbe_pkg::RT_RESYNC);
   assign rx_par_bad = ctrl_one[unbe_pkg::C1_PE] &
                       (nine ? (unbe_pkg::parity_of(rx_shift, unbe_pkg::MASK_PAR9,
                                                    ctrl_one[unbe_pkg::C1_PT]) != rx_shift[8])
                             : (unbe_pkg::parity_of(rx_shift, unbe_pkg::MASK_PAR8,
                                                    ctrl_one[unbe_pkg::C1_PT]) != rx_shift[7]));

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_state <= unbe_pkg::RX_HUNT;
         hist     <= 3'b000;
         votes    <= 3'b000;
         rx_rt    <= 4'h0;
         rx_bit   <= 4'h0;
         rx_shift <= 9'h000;
         rx_noise <= 1'b0;
         rx_done  <= 1'b0;
         rx_frame <= '0;
      end else begin
         rx_done <= 1'b0;
         if (tick && ctrl_two[unbe_pkg::C2_RE]) begin
            hist  <= {hist[1:0], rx_line};
            votes <= {votes[1:0], rx_line};
            rx_rt <= rx_rt + 1'b1;
            unique case (rx_state)
               unbe_pkg::RX_HUNT: begin
                  if (falling) begin
                     rx_state <= unbe_pkg::RX_START;
                     rx_rt    <= unbe_pkg::RT2;
                     rx_noise <= 1'b0;
                  end
               end
               unbe_pkg::RX_START: begin
                  if (rx_rt == unbe_pkg::RT7) begin
                     if (unbe_pkg::majority({votes[2], votes[0], rx_line})) begin
                        rx_state <= unbe_pkg::RX_HUNT;
                     end
                  end else if (rx_rt == unbe_pkg::RT16) begin
                     rx_state <= unbe_pkg::RX_DATA;
                     rx_bit   <= 4'h0;
                  end
               end
               unbe_pkg::RX_DATA: begin
                  if (rx_rt == unbe_pkg::RT10) begin
                     rx_shift[rx_bit] <= bit_val;
                     rx_noise <= rx_noise | bit_noisy;
                  end
                  if (rx_rt == unbe_pkg::RT16 || resync) begin
                     if (resync) begin
                        rx_rt <= unbe_pkg::RT2;
                     end
                     if (rx_bit == (nine ? unbe_pkg::RX_BITS9 : unbe_pkg::RX_BITS8) - 1'b1) begin
                        rx_state <= unbe_pkg::RX_STOP;
                     end else begin
                        rx_bit <= rx_bit + 1'b1;
                     end
                  end
               end
               unbe_pkg::RX_STOP: begin
                  if (rx_rt == unbe_pkg::RT10) begin
                     rx_state        <= unbe_pkg::RX_HUNT;
                     rx_done         <= 1'b1;
                     rx_frame.word   <= nine ? rx_shift : {1'b0, rx_shift[7:0]};
                     rx_frame.noise  <= rx_noise | bit_noisy;
                     rx_frame.frame  <= ~bit_val;
                     rx_frame.parity <= rx_par_bad;
                     if (!bit_val && rx_shift != 9'h000) begin
                        hist <= 3'b111;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Status flags and receive buffer; set wins over clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status    <= unbe_pkg::STATUS_RESET;
         rx_buf    <= unbe_pkg::DATA_RESET;
      end else begin
         status.idle <= 1'b0;
         if (data_rd_clear) begin
            status.rdrf   <= 1'b0;
            status.ovr    <= 1'b0;
            status.noise  <= 1'b0;
            status.frame  <= 1'b0;
            status.parity <= 1'b0;
         end
         if (data_wr_clear) begin
            status.tdre <= 1'b0;
            status.tc   <= 1'b0;
         end
         if (tx_take) begin
            status.tdre <= 1'b1;
         end
         if (tx_done) begin
            status.tc <= 1'b1;
         end
         if (rx_done && !(status.frame && !data_rd_clear)) begin
            if (status.rdrf && !data_rd_clear) begin
               status.ovr <= 1'b1;
            end else begin
               rx_buf        <= rx_frame.word[7:0];
               status.rdrf   <= 1'b1;
               status.noise  <= rx_frame.noise;
               status.frame  <= rx_frame.frame;
               status.parity <= rx_frame.parity;
            end
         end
      end
   end

   // Control three; bit 7 follows each accepted frame
   logic rx_accept;

   assign rx_accept = rx_done & ~(status.frame & ~data_rd_clear) &
                      ~(status.rdrf & ~data_rd_clear);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl3 <= unbe_pkg::CTRL3_RESET;
      end else begin
         if (rx_accept) begin
            ctrl3.rx9 <= rx_frame.word[8];
         end
         if (wr && unbe_pkg::idx_hit(wb_adr, unbe_pkg::IDX_CTRL_THREE)) begin
            ctrl3[6:0] <= wb_dat_w[6:0];
         end
      end
   end

   // Masked error interrupt request
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         error_irq <= 1'b0;
      end else begin
         error_irq <= (status.ovr & ctrl3.overrun_irq_enable)
                    | (status.noise & ctrl3.noise_irq_enable)
                    | (status.frame & ctrl3.framing_irq_enable)
                    | (status.parity & ctrl3.parity_irq_enable);
      end
   end
endmodule // unbe_serial_port

//--- dv/unbe_serial_port_asserts.sv
// Bus and line checks for the serial port
`timescale 1ns/10ps
module unbe_serial_port_asserts (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        wb_cyc,
   input wire logic        wb_stb,
   input wire logic        wb_we,
   input wire logic [11:0] wb_adr,
   input wire logic [31:0] wb_dat_r,
   input wire logic        wb_ack,
   input wire logic        tx_pin,
   input wire logic        error_irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence held8;
      $stable(tx_pin)[*8];
   endsequence
   ack_pulse_a: assert property (wb_ack |=> !wb_ack) else $error("ack too long");
   ack_latency_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
      else $error("ack late");
   ack_cause_a: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
      else $error("ack without request");
   high_zero_a: assert property (wb_ack |-> wb_dat_r[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   unmapped_zero_a: assert property (wb_ack && !wb_we && wb_adr[11:8] == 4'h0
      |-> wb_dat_r == 32'h0000_0000) else $error("unmapped read not zero");
   rdata_hold_a: assert property ($changed(wb_dat_r) |-> $past(wb_cyc && !wb_we))
      else $error("read data moved");
   irq_clear_a: assert property ($fell(error_irq)
      |-> $past(wb_cyc) || $past(wb_cyc, 2)) else $error("irq fell without access");
   bit_hold_a: assert property ($changed(tx_pin) && !$past(wb_ack) |=> held8)
      else $error("line bit too short");
endmodule // unbe_serial_port_asserts

bind unbe_serial_port unbe_serial_port_asserts i_chk (.mclk(mclk), .rst_n(rst_n),
   .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_r(wb_dat_r),
   .wb_ack(wb_ack), .tx_pin(tx_pin), .error_irq(error_irq));

//--- dv/unbe_remote_node.sv
// Remote serial node sending and capturing frames
`timescale 1ns/10ps
module unbe_remote_node (
   input  wire logic mclk,
   input  wire logic line_in,
   output logic      line_out
);
   initial line_out = 1'b1;
   task automatic send(input logic [8:0] w, input logic stp);
      logic [10:0] f;
      f = {stp, w, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge mclk);
         line_out <= f[i];
         repeat (15) @(posedge mclk);
      end
      @(posedge mclk);
      line_out <= 1'b1;
   endtask
   task automatic grab(input logic inv, output logic [8:0] w, output logic ok);
      int n;
      n = 0;
      while ((line_in ^ inv) !== 1'b0 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      repeat (8) @(posedge mclk);
      for (int i = 0; i < 9; i++) begin
         repeat (16) @(posedge mclk);
         w[i] = line_in ^ inv;
      end
      repeat (16) @(posedge mclk);
      ok = n < 200 && (line_in ^ inv) === 1'b1;
   endtask
endmodule // unbe_remote_node

//--- dv/uart_ninth_bit_and_error_irq_tb.sv
// Self-checking bench of the serial port
`timescale 1ns/10ps
module uart_ninth_bit_and_error_irq_tb;
   logic        mclk;
   logic        rst_n;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [11:0] wb_adr;
   logic [31:0] wb_dat_w;
   logic [31:0] wb_dat_r;
   logic        wb_ack;
   logic        rx_pin;
   logic        tx_pin;
   logic        tx_pin_oe_n;
   logic        error_irq;
   logic [8:0]  q;
   logic [8:0]  w;
   logic        ok;
   int          mismatches;
   int          samples_checked;
   wire         tx_pin_in = tx_pin_oe_n ? 1'b1 : tx_pin;
   unbe_serial_port i_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hf), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
      .wb_ack(wb_ack), .rx_pin(rx_pin), .tx_pin_in(tx_pin_in), .tx_pin(tx_pin),
      .tx_pin_oe_n(tx_pin_oe_n), .error_irq(error_irq));
   unbe_remote_node i_node (.mclk(mclk), .line_in(tx_pin), .line_out(rx_pin));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= {2'b00, idx, 2'b00};
      wb_dat_w <= {24'h00_0000, d};
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      q = wb_dat_r[8:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 50) begin
         chk(9'h000, 9'h001);
         tally_and_finish();
      end
   endtask
   task automatic irq_is(input logic v);
      repeat (3) @(posedge mclk);
      chk({8'h00, error_irq}, {8'h00, v});
   endtask
   task automatic t_reset();
      bus(1'b0, 8'h47, 8'h00);
      chk(q, 9'h000);
      bus(1'b0, 8'h44, 8'h00);
      chk(q, 9'h0c0);
      bus(1'b0, 8'h10, 8'h00);
      chk(q, 9'h000);
      chk({8'h00, tx_pin}, 9'h001);
      $display("reset test done");
   endtask
   task automatic t_tx();
      bus(1'b1, 8'h42, 8'h10);
      bus(1'b1, 8'h43, 8'h0c);
      bus(1'b1, 8'h46, 8'h50);
      irq_is(1'b0);
      chk({8'h00, tx_pin}, 9'h000);
      bus(1'b0, 8'h44, 8'h00);
      bus(1'b1, 8'h47, 8'ha5);
      i_node.grab(1'b1, w, ok);
      chk(w, 9'h1a5);
      chk({8'h00, ok}, 9'h001);
      repeat (8) @(posedge mclk);
      bus(1'b1, 8'h46, 8'h00);
      irq_is(1'b0);
      chk({8'h00, tx_pin}, 9'h001);
      $display("transmit test done");
   endtask
   task automatic t_rx();
      i_node.send(9'h13c, 1'b1);
      bus(1'b0, 8'h44, 8'h00);
      chk({8'h00, q[5]}, 9'h001);
      bus(1'b0, 8'h46, 8'h00);
      chk({8'h00, q[7]}, 9'h001);
      bus(1'b0, 8'h47, 8'h00);
      chk(q, 9'h03c);
      bus(1'b0, 8'h44, 8'h00);
      chk({8'h00, q[5]}, 9'h000);
      $display("receive test done");
   endtask
   task automatic t_irq();
      bus(1'b1, 8'h46, 8'h08);
      i_node.send(9'h011, 1'b1);
      i_node.send(9'h022, 1'b1);
      irq_is(1'b1);
      bus(1'b1, 8'h46, 8'h07);
      irq_is(1'b0);
      bus(1'b0, 8'h44, 8'h00);
      chk({8'h00, q[3]}, 9'h001);
      bus(1'b0, 8'h47, 8'h00);
      bus(1'b1, 8'h46, 8'h02);
      i_node.send(9'h0f0, 1'b0);
      irq_is(1'b1);
      bus(1'b1, 8'h46, 8'h0d);
      irq_is(1'b0);
      bus(1'b0, 8'h44, 8'h00);
      bus(1'b0, 8'h47, 8'h00);
      bus(1'b1, 8'h46, 8'h02);
      irq_is(1'b0);
      $display("error irq test done");
   endtask
   task automatic t_parity();
      repeat (200) @(posedge mclk);
      bus(1'b0, 8'h44, 8'h00);
      bus(1'b0, 8'h47, 8'h00);
      bus(1'b1, 8'h42, 8'h13);
      bus(1'b1, 8'h46, 8'h01);
      i_node.send(9'h000, 1'b1);
      irq_is(1'b1);
      bus(1'b0, 8'h44, 8'h00);
      chk({8'h00, q[0]}, 9'h001);
      bus(1'b1, 8'h46, 8'h0e);
      irq_is(1'b0);
      $display("parity test done");
   endtask
   task automatic t_wire();
      bus(1'b1, 8'h42, 8'hb0);
      bus(1'b1, 8'h46, 8'h00);
      irq_is(1'b0);
      chk({8'h00, tx_pin_oe_n}, 9'h001);
      bus(1'b1, 8'h46, 8'h20);
      irq_is(1'b0);
      chk({8'h00, tx_pin_oe_n}, 9'h000);
      $display("single wire test done");
   endtask
   initial begin
      rst_n           = 1'b0;
      wb_cyc          = 1'b0;
      wb_stb          = 1'b0;
      wb_we           = 1'b0;
      wb_adr          = 12'h000;
      wb_dat_w        = 32'h0000_0000;
      mismatches      = 0;
      samples_checked = 0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_tx();
      t_rx();
      t_irq();
      t_parity();
      t_wire();
      tally_and_finish();
   end
endmodule // uart_ninth_bit_and_error_irq_tb
